// File: verilog/slidr_sector_lock.sv
// Notes on behaviour
// RULE1: one 8-bit lock per sector; bits 7:2 read zero, bit1 lock-down, bit0 protect.
// RULE2: lock write runs only when the addressed lock-down flag is zero.
// RULE3: lock read returns the addressed sector's lock register.
// RULE4: lock-down zero after reset; once set, both flags frozen until reset.
// RULE5: write-protect zero after reset, so program and erase are allowed.
// RULE6: program or erase to a protected sector is refused.
// RULE7: both identification read commands deliver the same byte sequence.
// RULE8: identification byte 1 is the manufacturer code.
// RULE9: bytes 2 and 3 are memory type and capacity codes.
// RULE10: byte 4 holds remaining byte count, 10h.
// RULE11: byte 5 is extended identifier; byte 6 is 00h standard configuration.
// RULE12: bytes 7 to 20 are a 14-byte factory unique identifier.
// RULE13: extended byte: generation, block-protect scheme, pin function, reset pin, sector size.
// RULE14: parameter-table read command returns the discoverable parameter table.
// RULE15: every reset clears all write-protect flags, unlocking all sectors.
// RULE16: host should set write-protect before or with lock-down.
module slidr_sector_lock
   import slidr_pkg::*;
#(
   parameter logic [UNIQUE_IDENTIFIER_LEN*8-1:0] UNIQUE_IDENTIFIER = '0,
   parameter logic SECOND_GENERATION = 1'b1,
   parameter logic ALT_BLOCK_PROTECT_SCHEME = 1'b0,
   parameter logic RESET_PIN_FUNCTION = 1'b0,
   parameter logic EXTRA_HW_RESET_PIN = 1'b0,
   parameter logic [PARAM_DEPTH*8-1:0] PARAM_TABLE = '0
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // command port
   input wire logic req_valid,
   input wire slidr_req_t req,
   output logic [7:0] rsp_data,
   output logic rsp_valid,
   // program and erase gating
   input wire logic pe_valid,
   input wire slidr_pe_t pe,
   output logic pe_grant,
   output logic pe_refused
);

   // decoded request strobes
   logic lock_write_req;
   logic lock_read_req;
   logic ident_read_req;
   logic param_read_req;
   logic soft_reset_req;
   logic read_req;
   logic lock_write_allowed;
   // stored flags, one array per flag
   logic lockdown_reg [SECTOR_COUNT];
   logic write_protect_reg [SECTOR_COUNT];
   // flags of the sectors addressed this cycle
   logic req_lockdown;
   logic req_write_protect;
   logic [1:0] req_sector_flags;
   logic pe_sector_protected;
   // answer byte sources
   logic [7:0] extended_identifier_byte;
   logic [7:0] rsp_next;

   // one strobe for one command code
   function automatic logic cmd_hit(input logic v, input slidr_cmd_t c, input slidr_cmd_t want);
      return v && (c == want);
   endfunction

   // lock register image; reserved bits read zero
   function automatic logic [7:0] lock_byte(input logic [1:0] f);
      logic [7:0] b;
      b = 8'h00;
      b[LOCKDOWN_BIT] = f[1];
      b[WRITE_PROTECT_BIT] = f[0];
      return b; // RULE1
   endfunction

   // unique identifier bytes, first one in the lowest bits
   function automatic logic [7:0] unique_identifier_byte(input logic [PARAM_ADDR_W-1:0] i);
      int k;
      k = int'(i) - ID_IDX_UNIQUE_FIRST;
      return UNIQUE_IDENTIFIER[k*8 +: 8]; // RULE12
   endfunction

   // parameter table bytes, byte 0 in the lowest bits
   function automatic logic [7:0] param_byte(input logic [PARAM_ADDR_W-1:0] i);
      return PARAM_TABLE[int'(i)*8 +: 8]; // RULE14
   endfunction

   // identification sequence; index is the byte number minus one
   function automatic logic [7:0] ident_byte(input logic [PARAM_ADDR_W-1:0] i, input logic [7:0] ext);
      logic [7:0] b;
      b = 8'h00;
      if (i == 8'(ID_IDX_MANUFACTURER)) begin
         b = MANUFACTURER_CODE; // RULE8
      end else if (i == 8'(ID_IDX_MEMORY_TYPE)) begin
         b = MEMORY_TYPE_CODE; // RULE9
      end else if (i == 8'(ID_IDX_MEMORY_CAPACITY)) begin
         b = MEMORY_CAPACITY_CODE; // RULE9
      end else if (i == 8'(ID_IDX_REMAINING)) begin
         b = REMAINING_COUNT; // RULE10
      end else if (i == 8'(ID_IDX_EXTENDED)) begin
         b = ext; // RULE11
      end else if (i == 8'(ID_IDX_CONFIG)) begin
         b = CONFIG_STANDARD; // RULE11
      end else if (i < 8'(ID_LEN)) begin
         b = unique_identifier_byte(i); // RULE12
      end
      return b;
   endfunction

   // extended identifier, fixed by the build options
   always_comb begin
      extended_identifier_byte = 8'h00;
      extended_identifier_byte[EXT_GEN_BIT] = SECOND_GENERATION; // RULE13
      extended_identifier_byte[EXT_BLOCK_PROTECT_SCHEME_BIT] = ALT_BLOCK_PROTECT_SCHEME; // RULE13
      extended_identifier_byte[EXT_PINFN_BIT] = RESET_PIN_FUNCTION; // RULE13
      extended_identifier_byte[EXT_HWRST_BIT] = EXTRA_HW_RESET_PIN; // RULE13
      extended_identifier_byte[1:0] = SECTOR_SIZE_UNIFORM_64K; // RULE13
   end

   // command decode
   always_comb begin
      lock_write_req = cmd_hit(req_valid, req.cmd, CMD_LOCK_WRITE);
      lock_read_req = cmd_hit(req_valid, req.cmd, CMD_LOCK_READ);
      ident_read_req = cmd_hit(req_valid, req.cmd, CMD_IDENT_READ)
                       || cmd_hit(req_valid, req.cmd, CMD_MULTILINE_IDENT_READ); // RULE7
      param_read_req = cmd_hit(req_valid, req.cmd, CMD_PARAM_READ);
      soft_reset_req = cmd_hit(req_valid, req.cmd, CMD_SOFT_RESET);
      read_req = lock_read_req || ident_read_req || param_read_req;
   end

   // addressed flags; a set lock-down flag blocks any lock write to its own sector
   always_comb begin
      req_lockdown = lockdown_reg[req.sector];
      req_write_protect = write_protect_reg[req.sector];
      req_sector_flags = {req_lockdown, req_write_protect};
      lock_write_allowed = lock_write_req && !req_lockdown; // RULE2 RULE4
      pe_sector_protected = write_protect_reg[pe.sector]; // RULE6
   end

   // lock-down flags; once set only a reset clears them
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int s = 0; s < SECTOR_COUNT; s++) begin
            lockdown_reg[s] <= LOCK_RESET[LOCKDOWN_BIT]; // RULE4
         end
      end else if (soft_reset_req) begin
         for (int s = 0; s < SECTOR_COUNT; s++) begin
            lockdown_reg[s] <= LOCK_RESET[LOCKDOWN_BIT]; // RULE4
         end
      end else if (lock_write_allowed) begin
         lockdown_reg[req.sector] <= req.data[LOCKDOWN_BIT] & LOCK_WRITABLE_MASK[LOCKDOWN_BIT]; // RULE2 RULE4
      end
   end

   // write-protect flags; every reset unlocks every sector
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int s = 0; s < SECTOR_COUNT; s++) begin
            write_protect_reg[s] <= LOCK_RESET[WRITE_PROTECT_BIT]; // RULE5 RULE15
         end
      end else if (soft_reset_req) begin
         for (int s = 0; s < SECTOR_COUNT; s++) begin
            write_protect_reg[s] <= LOCK_RESET[WRITE_PROTECT_BIT]; // RULE15
         end
      end else if (lock_write_allowed) begin
         write_protect_reg[req.sector] <= req.data[WRITE_PROTECT_BIT] & LOCK_WRITABLE_MASK[WRITE_PROTECT_BIT]; // RULE2
      end
   end

   // answer byte for the command now on the port
   always_comb begin
      rsp_next = 8'h00;
      unique case (req.cmd)
         CMD_LOCK_READ: begin
            rsp_next = lock_byte(req_sector_flags); // RULE3
         end
         CMD_IDENT_READ, CMD_MULTILINE_IDENT_READ: begin
            rsp_next = ident_byte(req.index, extended_identifier_byte); // RULE7
         end
         CMD_PARAM_READ: begin
            rsp_next = param_byte(req.index); // RULE14
         end
         CMD_NONE, CMD_LOCK_WRITE, CMD_SOFT_RESET: begin
            rsp_next = 8'h00;
         end
         default: begin
            rsp_next = 8'h00;
         end
      endcase
   end

   // answer strobe, one cycle per read command
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'h0;
      end else begin
         rsp_valid <= read_req; // RULE3 RULE7 RULE14
      end
   end

   // answer byte, zero when nothing is read
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rsp_data <= 8'h00;
      end else begin
         rsp_data <= read_req ? rsp_next : 8'h00;
      end
   end

   // program and erase answers, one cycle after the request
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pe_grant <= 1'h0;
      end else begin
         pe_grant <= pe_valid && !pe_sector_protected; // RULE5 RULE6
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pe_refused <= 1'h0;
      end else begin
         pe_refused <= pe_valid && pe_sector_protected; // RULE6
      end
   end

endmodule

// File: verilog/slidr_pkg.sv
package slidr_pkg;
   // sector addressing
   localparam int SECTOR_ADDR_W = 9;
   localparam int SECTOR_COUNT = 512;
   localparam int LOCK_W = 8;
   // lock register layout
   localparam int LOCKDOWN_BIT = 1;
   localparam int WRITE_PROTECT_BIT = 0;
   localparam logic [7:0] LOCK_RESET = 8'h00;
   localparam logic [7:0] LOCK_WRITABLE_MASK = 8'h03;
   // identification sequence
   localparam int ID_LEN = 20;
   localparam int UNIQUE_IDENTIFIER_LEN = 14;
   localparam int ID_IDX_W = 5;
   // position of each field in the identification sequence
   localparam int ID_IDX_MANUFACTURER = 0;
   localparam int ID_IDX_MEMORY_TYPE = 1;
   localparam int ID_IDX_MEMORY_CAPACITY = 2;
   localparam int ID_IDX_REMAINING = 3;
   localparam int ID_IDX_EXTENDED = 4;
   localparam int ID_IDX_CONFIG = 5;
   localparam int ID_IDX_UNIQUE_FIRST = 6;
   // arbitrary neutral identity values
   localparam logic [7:0] MANUFACTURER_CODE = 8'h5c;
   localparam logic [7:0] MEMORY_TYPE_CODE = 8'h6d;
   localparam logic [7:0] MEMORY_CAPACITY_CODE = 8'h3e;
   localparam logic [7:0] REMAINING_COUNT = 8'h10;
   localparam logic [7:0] CONFIG_STANDARD = 8'h00;
   // extended identifier fields
   localparam int EXT_GEN_BIT = 6;
   localparam int EXT_BLOCK_PROTECT_SCHEME_BIT = 5;
   localparam int EXT_PINFN_BIT = 3;
   localparam int EXT_HWRST_BIT = 2;
   localparam logic [1:0] SECTOR_SIZE_UNIFORM_64K = 2'h0;
   // parameter table
   localparam int PARAM_ADDR_W = 8;
   localparam int PARAM_DEPTH = 256;

   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_LOCK_WRITE = 3'b001,
      CMD_LOCK_READ = 3'b010,
      CMD_IDENT_READ = 3'b011,
      CMD_MULTILINE_IDENT_READ = 3'b100,
      CMD_PARAM_READ = 3'b101,
      CMD_SOFT_RESET = 3'b110
   } slidr_cmd_t;

   typedef struct packed {
      slidr_cmd_t cmd;
      logic [SECTOR_ADDR_W-1:0] sector;
      logic [7:0] data;
      logic [PARAM_ADDR_W-1:0] index;
   } slidr_req_t;

   typedef struct packed {
      logic [SECTOR_ADDR_W-1:0] sector;
      logic is_erase;
   } slidr_pe_t;
endpackage

// File: test/slidr_sva.sv
module slidr_sva
   import slidr_pkg::*;
(
   input wire logic clock, rst, req_valid, rsp_valid, pe_valid, pe_grant, pe_refused,
   input wire slidr_req_t req,
   input wire logic [7:0] rsp_data
);
   timeunit 1ns/1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire idr = req_valid && req.cmd inside {CMD_IDENT_READ, CMD_MULTILINE_IDENT_READ};
   sequence s_unl; req_valid && req.cmd == CMD_SOFT_RESET ##1 !req_valid ##1 pe_valid; endsequence
   property p_lk; req_valid && req.cmd == CMD_LOCK_READ |=> rsp_valid && rsp_data[7:2] == 6'h0; endproperty
   a_lk: assert property (p_lk) else $error("lock read");
   property p_mf; idr && req.index == 8'h0 |=> rsp_valid && rsp_data == MANUFACTURER_CODE; endproperty
   a_mf: assert property (p_mf) else $error("maker byte");
   property p_cn; idr && req.index == 8'h3 |=> rsp_data == 8'h10; endproperty
   a_cn: assert property (p_cn) else $error("count byte");
   property p_ex; idr && req.index == 8'h4 |=> rsp_data[1:0] == SECTOR_SIZE_UNIFORM_64K; endproperty
   a_ex: assert property (p_ex) else $error("ext byte");
   property p_cf; idr && req.index == 8'h5 |=> rsp_data == CONFIG_STANDARD; endproperty
   a_cf: assert property (p_cf) else $error("config byte");
   property p_pe; pe_valid |=> pe_grant != pe_refused; endproperty
   a_pe: assert property (p_pe) else $error("pe answer");
   property p_id; !pe_valid |=> !pe_grant && !pe_refused; endproperty
   a_id: assert property (p_id) else $error("pe idle");
   property p_un; s_unl |=> pe_grant; endproperty
   a_un: assert property (p_un) else $error("unlock");
endmodule
bind slidr_sector_lock slidr_sva u_slidr_sva(.clock, .rst, .req_valid, .rsp_valid, .pe_valid, .pe_grant,
   .pe_refused, .req, .rsp_data);

// File: test/slidr_host.sv
module slidr_host
   import slidr_pkg::*;
(
   input wire logic clock, pe_grant, pe_refused,
   input wire logic [7:0] rsp_data,
   output slidr_req_t req,
   output slidr_pe_t pe,
   output logic req_valid, pe_valid
);
   timeunit 1ns/1ns;
   initial {req, pe, req_valid, pe_valid} = '0;
   // CMD_NONE issues an erase; idle request lines are scrambled
   task automatic op(input slidr_cmd_t c, input logic [8:0] s, input logic [7:0] d, i, output logic [7:0] r);
      @(negedge clock) {req, pe} = {c, s, d, i, s, 1'h1};
      req_valid = c != CMD_NONE;
      pe_valid = c == CMD_NONE;
      @(negedge clock) r = pe_valid ? {6'h0, pe_grant, pe_refused} : rsp_data;
      {req, pe, req_valid, pe_valid} = {~req, ~pe, 2'h0};
   endtask
endmodule

// File: test/slidr_sector_lock_bench.sv
module slidr_sector_lock_bench
   import slidr_pkg::*;
;
   timeunit 1ns/1ns;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic req_valid, pe_valid, pe_grant, pe_refused;
   logic [7:0] rsp_data, r;
   slidr_req_t req;
   slidr_pe_t pe;
   int bad_count = 0;
   int check_count = 0;
   always #20 clock = ~clock;
   // identifier byte at index i holds 80h plus i; table bytes 0 and 1 are 3ch and 5ah
   slidr_sector_lock #(
      .UNIQUE_IDENTIFIER(112'h9392_9190_8f8e_8d8c_8b8a_8988_8786),
      .PARAM_TABLE((PARAM_DEPTH*8)'(16'h5a3c))
   ) u_slidr_sector_lock(.clock, .rst, .req_valid, .req, .rsp_data, .rsp_valid(), .pe_valid, .pe,
      .pe_grant, .pe_refused);
   slidr_host u_slidr_host(.clock, .pe_grant, .pe_refused, .rsp_data, .req, .pe, .req_valid, .pe_valid);
   task automatic chk(input logic [7:0] g, e);
      check_count++;
      if (g !== e) bad_count++;
      if (g !== e) $display("Error %0t: got %h want %h", $time, g, e);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic t_lock();
      u_slidr_host.op(CMD_NONE, 9'h1ff, '0, '0, r);
      chk(r, 8'h02);
      u_slidr_host.op(CMD_LOCK_WRITE, 9'h7, 8'hff, '0, r);
      u_slidr_host.op(CMD_LOCK_READ, 9'h7, '0, '0, r);
      chk(r, 8'h03);
      u_slidr_host.op(CMD_LOCK_WRITE, 9'h7, '0, '0, r);
      u_slidr_host.op(CMD_LOCK_READ, 9'h7, '0, '0, r);
      chk(r, 8'h03);
      u_slidr_host.op(CMD_NONE, 9'h7, '0, '0, r);
      chk(r, 8'h01);
      u_slidr_host.op(CMD_SOFT_RESET, '0, '0, '0, r);
      u_slidr_host.op(CMD_NONE, 9'h7, '0, '0, r);
      chk(r, 8'h02);
      u_slidr_host.op(CMD_LOCK_READ, 9'h7, '0, '0, r);
      chk(r, 8'h00);
   endtask
   task automatic t_hw_reset();
      u_slidr_host.op(CMD_LOCK_WRITE, 9'h9, 8'h03, '0, r);
      u_slidr_host.op(CMD_LOCK_READ, 9'h9, '0, '0, r);
      chk(r, 8'h03);
      @(negedge clock) rst = 1'h1;
      repeat (2) @(negedge clock);
      rst = 1'h0;
      u_slidr_host.op(CMD_NONE, 9'h9, '0, '0, r);
      chk(r, 8'h02);
      u_slidr_host.op(CMD_LOCK_READ, 9'h9, '0, '0, r);
      chk(r, 8'h00);
   endtask
   task automatic t_ident();
      logic [7:0] e [6] = '{MANUFACTURER_CODE, MEMORY_TYPE_CODE, MEMORY_CAPACITY_CODE, 8'h10, 8'h40, CONFIG_STANDARD};
      for (int c = 3; c < 5; c++) begin
         for (int i = 0; i < 21; i++) begin
            u_slidr_host.op(slidr_cmd_t'(c), '0, '0, 8'(i), r);
            chk(r, i < 6 ? e[i] : (i < 20 ? 8'(8'h80 + i) : 8'h00));
         end
      end
      u_slidr_host.op(CMD_PARAM_READ, '0, '0, 8'h00, r);
      chk(r, 8'h3c);
      u_slidr_host.op(CMD_PARAM_READ, '0, '0, 8'h01, r);
      chk(r, 8'h5a);
      u_slidr_host.op(CMD_PARAM_READ, '0, '0, 8'hff, r);
      chk(r, 8'h00);
   endtask
   initial begin
      repeat (4) @(negedge clock);
      rst = 1'h0;
      t_lock();
      t_hw_reset();
      t_ident();
      final_report();
   end
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
endmodule
